// File: rtl/bst_pkg.sv
/*
 * Constants, types and register map of the bridge brake and bootstrap
 * controller. Assumes a 10 MHz system clock and an APB master.
 */
package bst_pkg;

    localparam int CLK_MHZ        = 10;
    localparam int BOOT_MIN_US    = 7;
    localparam int BOOT_TMO_US    = 200;
    localparam int BOOT_MIN_CYC   = BOOT_MIN_US * CLK_MHZ;
    localparam int BOOT_TMO_CYC   = BOOT_TMO_US * CLK_MHZ;
    localparam int BOOT_CNT_W     = 11;
    localparam int NUM_PHASES     = 2;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_DEAD   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0c;
    localparam logic [7:0] REG_STATE  = 8'h10;

    // reset values
    localparam logic       CTRL_RST   = 1'b0;
    localparam logic [7:0] DEAD_RST   = 8'h04;
    localparam logic [3:0] MASK_RST   = 4'h0;

    // status bit positions
    localparam int ST_FAULT_A  = 0;
    localparam int ST_FAULT_B  = 1;
    localparam int ST_CHARGE_A = 2;
    localparam int ST_CHARGE_B = 3;

    typedef enum logic [2:0] {
        BST_IDLE   = 3'b001,
        BST_CHARGE = 3'b010,
        BST_FAULT  = 3'b100
    } bst_boot_state_e;

    typedef struct packed {
        logic sync_rect_en;
        logic hi_side_pwm;
        logic lo_side_pwm;
        logic phase_dir;
    } bst_cmd_s;

    typedef struct packed {
        logic [NUM_PHASES-1:0] hi;
        logic [NUM_PHASES-1:0] lo;
    } bst_gate_s;

endpackage

// File: rtl/bst_boot_phase.sv
/*
 * Bootstrap charge manager for one bridge phase: forces a recharge and
 * times it. Assumes the comparator input is synchronous to sys_clk.
 */
module bst_boot_phase
    import bst_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // comparator
    input  wire logic boot_uv_low,
    // results
    output logic      force_lo,
    output logic      fault,
    output logic      start_pulse,
    output logic      fault_pulse
);

    bst_boot_state_e         state;
    bst_boot_state_e         next_state;
    logic [BOOT_CNT_W-1:0]   cnt;

    wire min_done = cnt >= BOOT_CNT_W'(BOOT_MIN_CYC - 1);
    wire tmo_hit  = cnt == BOOT_CNT_W'(BOOT_TMO_CYC - 1);

    always_comb begin
        next_state = state;
        unique case (state)
            // comparator watched in every drive state
            BST_IDLE: begin
                if (boot_uv_low)
                    next_state = BST_CHARGE;
            end
            // hold at least the minimum, longer while low
            BST_CHARGE: begin
                if (min_done && !boot_uv_low)
                    next_state = BST_IDLE;
                else if (tmo_hit)
                    next_state = BST_FAULT;
            end
            BST_FAULT: begin
                if (!boot_uv_low)
                    next_state = BST_IDLE;
            end
            default: next_state = BST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= BST_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            if (state == BST_IDLE)
                cnt <= '0;
            else if (!tmo_hit)
                cnt <= cnt + BOOT_CNT_W'(1);
        end
    end

    // low side forced while recharging or faulted
    assign force_lo    = state != BST_IDLE;
    assign fault       = state == BST_FAULT;
    assign start_pulse = state == BST_IDLE && next_state == BST_CHARGE;
    assign fault_pulse = state == BST_CHARGE && next_state == BST_FAULT;

endmodule

// File: rtl/bst_bridge_ctrl.sv
/*
 * Full-bridge gate control: decodes host drive commands, manages
 * bootstrap recharge per phase, inserts dead time, APB registers and
 * interrupt. Assumes host inputs synchronous to sys_clk, phase A = 0.
 */
module bst_bridge_ctrl
    import bst_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // host drive commands
    input  wire bst_cmd_s              cmd,
    // bootstrap comparators, high when charge is low
    input  wire logic [NUM_PHASES-1:0] boot_uv_low,
    // gate drives, fault flags and interrupt
    output bst_gate_s                  gate,
    output logic [NUM_PHASES-1:0]      boot_fault,
    output logic                       irq,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr
);

    logic                  bridge_en;
    logic [7:0]            dead_cyc;
    logic [3:0]            status;
    logic [3:0]            mask;

    logic [NUM_PHASES-1:0] force_lo;
    logic [NUM_PHASES-1:0] fault_lvl;
    logic [NUM_PHASES-1:0] start_pulse;
    logic [NUM_PHASES-1:0] fault_pulse;

    // per phase bootstrap managers
    genvar g;
    generate
        for (g = 0; g < NUM_PHASES; g++) begin : g_boot
            bst_boot_phase u_boot (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .boot_uv_low (boot_uv_low[g]),
                .force_lo    (force_lo[g]),
                .fault       (fault_lvl[g]),
                .start_pulse (start_pulse[g]),
                .fault_pulse (fault_pulse[g])
            );
        end
    endgenerate

    // host command decode; leg 0 drives when phase_dir high
    wire drv_hi_lo = cmd.hi_side_pwm && cmd.lo_side_pwm;
    wire off_hi    = !cmd.hi_side_pwm && cmd.lo_side_pwm;
    wire off_lo    = cmd.hi_side_pwm && !cmd.lo_side_pwm;
    wire [1:0] src_leg = cmd.phase_dir ? 2'b01 : 2'b10;
    wire [1:0] snk_leg = ~src_leg;

    // high-side off time with rectification brakes on low sides
    // brake is the plain rectified slow-decay decode
    wire [1:0] cmd_lo = drv_hi_lo ? snk_leg
                      : off_hi    ? (cmd.sync_rect_en ? 2'b11 : snk_leg)
                      : 2'b00;
    // low-side off time with rectification brakes on high sides
    wire [1:0] cmd_hi = drv_hi_lo ? src_leg
                      : off_lo    ? (cmd.sync_rect_en ? 2'b11 : src_leg)
                      : 2'b00;

    // forced low side pulls load node low to charge
    wire [1:0] want_lo = (bridge_en ? cmd_lo : 2'b00) | force_lo;
    wire [1:0] want_hi = (bridge_en ? cmd_hi : 2'b00) & ~force_lo;

    // dead time per leg
    logic [7:0] dt_hi [NUM_PHASES];
    logic [7:0] dt_lo [NUM_PHASES];

    generate
        for (g = 0; g < NUM_PHASES; g++) begin : g_dead
            wire hi_ok = !gate.lo[g] && dt_hi[g] == 8'h00;
            wire lo_ok = !gate.hi[g] && dt_lo[g] == 8'h00;
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    gate.hi[g] <= 1'b0;
                    gate.lo[g] <= 1'b0;
                    dt_hi[g]   <= 8'h00;
                    dt_lo[g]   <= 8'h00;
                end else begin
                    // dead time after low side or recharge ends
                    gate.hi[g] <= want_hi[g] && (gate.hi[g] || hi_ok);
                    gate.lo[g] <= want_lo[g] && (gate.lo[g] || lo_ok);
                    if (gate.lo[g])
                        dt_hi[g] <= dead_cyc;
                    else if (dt_hi[g] != 8'h00)
                        dt_hi[g] <= dt_hi[g] - 8'h01;
                    if (gate.hi[g])
                        dt_lo[g] <= dead_cyc;
                    else if (dt_lo[g] != 8'h00)
                        dt_lo[g] <= dt_lo[g] - 8'h01;
                end
            end
        end
    endgenerate

    // apb decode: one wait state, action on the pready edge
    wire acc      = psel && penable && pready;
    wire wr_acc   = acc && pwrite;
    wire rd_acc   = acc && !pwrite;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_dead = paddr == REG_DEAD;
    wire hit_stat = paddr == REG_STATUS;
    wire hit_mask = paddr == REG_MASK;
    wire hit_st   = paddr == REG_STATE;
    wire mapped   = hit_ctrl || hit_dead || hit_stat || hit_mask || hit_st;

    wire [3:0]  ev_set   = {start_pulse, fault_pulse};
    wire [3:0]  st_clr   = (rd_acc && hit_stat) ? 4'hf : 4'h0;
    wire [3:0]  next_status = (status & ~st_clr) | ev_set;
    wire [7:0]  state_word  = {force_lo, boot_uv_low, gate.lo, gate.hi};
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, bridge_en}
                       : hit_dead ? {24'h0, dead_cyc}
                       : hit_stat ? {28'h0, status}
                       : hit_mask ? {28'h0, mask}
                       : hit_st   ? {24'h0, state_word}
                       : 32'h0;
    wire next_pready = psel && penable && !pready;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= (next_pready && !pwrite) ? rd_mux : 32'h0;
            pslverr <= next_pready && !mapped;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bridge_en <= CTRL_RST;
            dead_cyc  <= DEAD_RST;
            mask      <= MASK_RST;
        end else if (wr_acc) begin
            if (hit_ctrl)
                bridge_en <= pwdata[0];
            if (hit_dead)
                dead_cyc <= pwdata[7:0];
            if (hit_mask)
                mask <= pwdata[3:0];
        end
    end

    // sticky events, set wins over read clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status     <= 4'h0;
            irq        <= 1'b0;
            boot_fault <= '0;
        end else begin
            status     <= next_status;
            irq        <= |(next_status & mask);
            // fault level shown on its own pins
            boot_fault <= fault_lvl;
        end
    end

endmodule

// File: sim/bst_bridge_ctrl_assertions.sv
/* Port checker for bst_bridge_ctrl.
   Assumes DEAD keeps its reset value. */
module bst_bridge_ctrl_assertions
    import bst_pkg::*;
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // bridge side
    input wire logic [NUM_PHASES-1:0] boot_uv_low,
    input wire bst_gate_s             gate,
    input wire logic [NUM_PHASES-1:0] boot_fault,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr
);
    logic [11:0] uv_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst || !boot_uv_low[1])
            uv_cnt <= 12'h000;
        else if (uv_cnt != 12'hfff)
            uv_cnt <= uv_cnt + 12'h001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_no_shoot; (gate.hi & gate.lo) == 2'h0; endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("hi and lo on");
    property p_dead; $fell(gate.lo[0]) |-> (!gate.hi[0])[*4]; endproperty
    a_dead: assert property (p_dead) else $error("no dead time");
    property p_force_a; $rose(boot_uv_low[0]) |-> ##[1:20] gate.lo[0]; endproperty
    a_force_a: assert property (p_force_a) else $error("lo a not forced");
    property p_force_b; $rose(boot_uv_low[1]) |-> ##[1:20] gate.lo[1]; endproperty
    a_force_b: assert property (p_force_b) else $error("lo b not forced");
    property p_hi_mask; $rose(boot_uv_low[0]) |-> ##3 (!gate.hi[0])[*8]; endproperty
    a_hi_mask: assert property (p_hi_mask) else $error("hi a during charge");
    property p_fault; uv_cnt == 12'h7da |-> boot_fault[1]; endproperty
    a_fault: assert property (p_fault) else $error("fault missing");
    property p_fault_early; $rose(boot_fault[1]) |-> uv_cnt >= 12'h7c6; endproperty
    a_fault_early: assert property (p_fault_early) else $error("fault early");
    property p_ready; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    a_ready: assert property (p_ready) else $error("pready timing");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
endmodule

// File: sim/bst_host_model.sv
/* Host controller model: turns a drive mode into commands.
   Assumes mode changes after a rising edge. */
module bst_host_model
    import bst_pkg::*;
(
    // clock and mode
    input  wire logic       sys_clk,
    input  wire logic [1:0] mode,
    // drive commands
    output bst_cmd_s        cmd
);
    always_ff @(posedge sys_clk) begin
        case (mode)
            2'h1: cmd <= '{1'b1, 1'b0, 1'b1, 1'b1};
            2'h2: cmd <= '{1'b1, 1'b1, 1'b0, 1'b1};
            // plain drive, phase b sources
            2'h3: cmd <= '{1'b0, 1'b1, 1'b1, 1'b0};
            default: cmd <= '0;
        endcase
    end
endmodule

// File: sim/tb_bst_bridge_ctrl.sv
/* Bench for bst_bridge_ctrl: braking, recharge, fault, registers.
   Assumes the host model and the port checker. */
module tb_bst_bridge_ctrl
    import bst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, irq, psel, penable, pwrite, pready, pslverr;
    logic [1:0] mode, uv, boot_fault;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    bst_cmd_s cmd;
    bst_gate_s gate;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    bst_host_model u_bst_host_model (.sys_clk, .mode, .cmd);
    bst_bridge_ctrl u_bst_bridge_ctrl (.sys_clk, .rst, .cmd, .boot_uv_low(uv), .gate,
        .boot_fault, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 10000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(REG_DEAD, {24'h0, DEAD_RST});
        rd(REG_MASK, 32'h0);
        apb(1'b1, REG_MASK, 32'hf, r, e);
        rd(REG_MASK, 32'hf);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, REG_CTRL, 32'h1, r, e);
        rd(REG_CTRL, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_brake();
        mode <= 2'h1;
        wt(20);
        chk({28'h0, gate}, 32'h3);
        mode <= 2'h3;
        wt(20);
        chk({28'h0, gate}, 32'h9);
        mode <= 2'h2;
        wt(20);
        chk({28'h0, gate}, 32'hc);
        rd(REG_STATE, 32'h3);
        $display("test brake done");
    endtask
    task automatic t_boot();
        uv <= 2'b01;
        wt(15);
        chk({28'h0, gate}, 32'h9);
        uv <= 2'b00;
        wt(40);
        chk({28'h0, gate}, 32'h9);
        wt(60);
        chk({28'h0, gate}, 32'hc);
        chk({31'h0, irq}, 32'h1);
        rd(REG_STATUS, 32'h4);
        rd(REG_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test boot done");
    endtask
    task automatic t_fault();
        mode <= 2'h0;
        uv <= 2'b10;
        wt(2100);
        chk({30'h0, boot_fault}, 32'h2);
        chk({28'h0, gate}, 32'h2);
        uv <= 2'b00;
        wt(5);
        chk({30'h0, boot_fault}, 32'h0);
        rd(REG_STATUS, 32'ha);
        $display("test fault done");
    endtask
    initial begin
        rst = 1'b1;
        mode = 2'h0;
        uv = 2'b00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wt(16);
        rst <= 1'b0;
        wt(1);
        t_regs();
        t_brake();
        t_boot();
        t_fault();
        test_done();
    end
endmodule
bind bst_bridge_ctrl bst_bridge_ctrl_assertions u_bst_bridge_ctrl_assertions (.sys_clk,
    .rst, .boot_uv_low, .gate, .boot_fault, .psel, .penable, .pready, .pslverr);
